// file: inc/fcu_pkg.sv
// Constants, types and field layout of the flash check unit.
// How it works
// RL1: Soft-reset strobe clears registers one cycle later
// RL2: Strobe accepted anytime while interrupt enable low
// RL3: Strobe ignored during scan if interrupt enabled
// RL4: Mismatch raises non-maskable request when enabled
// RL5: Interrupt enable cleared only by system reset
// RL6: Interrupt enable set only while not busy
// RL7: Enable write one starts scan, stays one
// RL8: Enable write zero does nothing
// RL9: Start-up scan leaves enable reading one
// RL10: Control register locked after failure interrupt
// RL11: Section select locked while busy or interrupted
// RL12: Selector codes whole, boot plus code, boot
// RL13: Start-up scan leaves checked section in selector
// RL14: Pass flag resets to one, status 0x02
// RL15: Software trusts pass flag only when idle
// RL16: Busy flag high for whole scan
// RL17: CRC x16+x12+x5+1, MSB first, init all ones
// RL18: Fetching begins three cycles after enable write
// RL19: Scan owns flash port, three cycles per word
// RL20: Stored checksum high byte then low byte last
// RL21: Completion clears busy, updates pass flag
package fcu_pkg;
    // Register indices; byte address is four times the index
    localparam logic [1:0] IDX_CONTROL = 2'h0;
    localparam logic [1:0] IDX_SECTION = 2'h1;
    localparam logic [1:0] IDX_STATE   = 2'h2;
    localparam int         AXI_AW      = 4;
    // Field positions
    localparam int BIT_ENABLE  = 0;
    localparam int BIT_FAIL_IE = 1;
    localparam int BIT_SOFTRST = 7;
    localparam int BIT_BUSY    = 0;
    localparam int BIT_PASS    = 1;
    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] SECTION_RESET = 2'h0;
    localparam logic [7:0] STATE_RESET   = 8'h02;
    // Section selector codes
    localparam logic [1:0] SEC_WHOLE         = 2'h0;
    localparam logic [1:0] SEC_BOOT_AND_CODE = 2'h1;
    localparam logic [1:0] SEC_BOOT          = 2'h2;
    // Checksum arithmetic
    localparam logic [15:0] CRC_POLY    = 16'h1021;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    // Cycle counts
    localparam logic [1:0] START_DELAY  = 2'h3;
    localparam logic [1:0] FETCH_CYCLES = 2'h3;
    // Flash byte address width
    localparam int FL_AW = 16;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Scan sequencer states
    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_WAIT,
        ST_FETCH,
        ST_CHECK
    } fcu_state_t;
    // Flash read request carried to the memory port
    typedef struct packed {
        logic             rd;
        logic [FL_AW-1:0] addr;
    } fcu_fl_req_t;
    // Status register fields
    typedef struct packed {
        logic pass;
        logic busy;
    } fcu_status_t;
endpackage

// file: logic/fcu_crc_byte.sv
// One byte through the sixteen-bit checksum shift register.
`timescale 1ns/1ps
module fcu_crc_byte (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  byte_in,
    output logic      [15:0] crc_out
);
    // Bitwise shift, most significant bit of the byte first
    always_comb begin
        logic [15:0] c;
        logic        fb;
        c  = crc_in;
        fb = 1'b0;
        // RL17 MSB first shift
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ byte_in[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ fcu_pkg::CRC_POLY;
            end
        end
        crc_out = c;
    end
endmodule

// file: logic/fcu_flash_check_unit.sv
// Flash check unit with AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fcu_flash_check_unit (
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    // AXI4-Lite slave
    input  wire logic [fcu_pkg::AXI_AW-1:0]  s_axi_awaddr_in,
    input  wire logic                        s_axi_awvalid_in,
    output logic                             s_axi_awready_out,
    input  wire logic [31:0]                 s_axi_wdata_in,
    input  wire logic [3:0]                  s_axi_wstrb_in,
    input  wire logic                        s_axi_wvalid_in,
    output logic                             s_axi_wready_out,
    output logic [1:0]                       s_axi_bresp_out,
    output logic                             s_axi_bvalid_out,
    input  wire logic                        s_axi_bready_in,
    input  wire logic [fcu_pkg::AXI_AW-1:0]  s_axi_araddr_in,
    input  wire logic                        s_axi_arvalid_in,
    output logic                             s_axi_arready_out,
    output logic [31:0]                      s_axi_rdata_out,
    output logic [1:0]                       s_axi_rresp_out,
    output logic                             s_axi_rvalid_out,
    input  wire logic                        s_axi_rready_in,
    // Start-up configuration, same clock
    input  wire logic                        boot_scan_in,
    input  wire logic [1:0]                  boot_section_in,
    // Last byte address of each section
    input  wire logic [fcu_pkg::FL_AW-1:0]   boot_end_in,
    input  wire logic [fcu_pkg::FL_AW-1:0]   code_end_in,
    input  wire logic [fcu_pkg::FL_AW-1:0]   flash_end_in,
    // Flash read port
    output fcu_pkg::fcu_fl_req_t             fl_req_out,
    input  wire logic [15:0]                 fl_rdata_in,
    // Processor side
    output logic                             cpu_stall_out,
    output logic                             cpu_run_out,
    output logic                             nmi_out
);
    // Sequencer state and scan datapath
    fcu_pkg::fcu_state_t           st_q;           // Scan state
    logic [1:0]                    cnt_q;          // Delay and fetch counter
    logic [fcu_pkg::FL_AW-2:0]     word_q;         // Word being fetched
    logic [15:0]                   crc_q;          // Checksum accumulator
    logic [15:0]                   crc_mid;        // After low byte
    logic [15:0]                   crc_d;          // After high byte
    logic [fcu_pkg::FL_AW-1:0]     end_addr;       // Last byte of section
    logic                          boot_q;         // Current scan is start-up scan
    logic                          run_q;          // Processor may execute
    // Register contents
    logic                          enable_q;       // Enable bit
    logic                          fail_ie_q;      // Failure interrupt enable
    logic [1:0]                    section_q;      // Section selector
    fcu_pkg::fcu_status_t          status_q;       // Pass and busy flags
    logic                          nmi_q;          // Sticky interrupt request
    logic                          soft_q;         // Accepted strobe, acts next cycle
    // Bus slave state
    logic                          aw_full_q;      // Write address held
    logic                          w_full_q;       // Write data held
    logic [fcu_pkg::AXI_AW-1:0]    awaddr_q;       // Held write address
    logic [31:0]                   wdata_q;        // Held write data
    logic                          wstrb0_q;       // Held lane 0 strobe
    logic                          bvalid_q;       // Write response pending
    logic [1:0]                    bresp_q;        // Write response code
    logic                          rvalid_q;       // Read data pending
    logic [31:0]                   rdata_q;        // Read data
    logic [1:0]                    rresp_q;        // Read response code
    // Decoded write
    logic                          aw_hs;
    logic                          w_hs;
    logic                          do_wr;
    logic [fcu_pkg::AXI_AW-1:0]    wr_addr;
    logic [31:0]                   wr_data;
    logic                          wr_lane0;
    logic                          wr_ctrl;
    logic                          soft_acc;
    logic                          start_req;
    logic                          ie_set;
    logic                          wr_sect;
    logic                          busy;
    logic                          last_word;
    logic                          scan_pass;

    // Address to register index, valid bit on top
    function automatic logic [2:0] reg_decode(input logic [fcu_pkg::AXI_AW-1:0] a);
        logic [1:0] idx;
        logic       ok;
        idx = a[3:2];
        ok  = (a[1:0] == 2'h0) && (idx != 2'h3);
        return {ok, idx};
    endfunction

    // Last byte address of a selected section
    function automatic logic [fcu_pkg::FL_AW-1:0] sect_end(input logic [1:0] s);
        case (s)
            // RL12 section codes
            fcu_pkg::SEC_BOOT_AND_CODE: sect_end = code_end_in;
            fcu_pkg::SEC_BOOT:          sect_end = boot_end_in;
            // Reserved code falls back to whole flash
            default:                    sect_end = flash_end_in;
        endcase
    endfunction

    // Low byte first: it sits at the lower address
    fcu_crc_byte u_crc_lo (
        .crc_in  (crc_q),
        .byte_in (fl_rdata_in[7:0]),
        .crc_out (crc_mid)
    );
    fcu_crc_byte u_crc_hi (
        .crc_in  (crc_mid),
        .byte_in (fl_rdata_in[15:8]),
        .crc_out (crc_d)
    );

    // Write decode; address and data in either order
    assign aw_hs    = s_axi_awvalid_in && s_axi_awready_out;
    assign w_hs     = s_axi_wvalid_in && s_axi_wready_out;
    assign do_wr    = (aw_full_q || aw_hs) && (w_full_q || w_hs) && !bvalid_q;
    assign wr_addr  = aw_full_q ? awaddr_q : s_axi_awaddr_in;
    assign wr_data  = w_full_q ? wdata_q : s_axi_wdata_in;
    assign wr_lane0 = w_full_q ? wstrb0_q : s_axi_wstrb_in[0];

    // RL16 busy over whole scan
    assign busy = (st_q == fcu_pkg::ST_WAIT) || (st_q == fcu_pkg::ST_FETCH)
                  || (st_q == fcu_pkg::ST_CHECK);

    // RL10 control locked after interrupt
    assign wr_ctrl = do_wr && wr_lane0 && !nmi_q
                     && (reg_decode(wr_addr) == {1'b1, fcu_pkg::IDX_CONTROL});
    // RL2 strobe free when enable low
    // RL3 strobe needs idle otherwise
    assign soft_acc  = wr_ctrl && wr_data[fcu_pkg::BIT_SOFTRST] && (!fail_ie_q || !busy);
    // RL7 write one starts scan
    // RL8 zero write ignored
    assign start_req = wr_ctrl && !soft_acc && wr_data[fcu_pkg::BIT_ENABLE] && !busy;
    // RL6 enable set only idle
    assign ie_set    = wr_ctrl && !soft_acc && wr_data[fcu_pkg::BIT_FAIL_IE] && !busy;
    // RL11 section lock
    assign wr_sect   = do_wr && wr_lane0 && !busy && !nmi_q
                       && (reg_decode(wr_addr) == {1'b1, fcu_pkg::IDX_SECTION});

    assign end_addr  = sect_end(section_q);
    assign last_word = (word_q == end_addr[fcu_pkg::FL_AW-1:1]);
    // RL20 stored checksum leaves zero residue
    assign scan_pass = (crc_q == fcu_pkg::CRC_RESIDUE);

    // Write address holding register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end else if (aw_hs) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_in;
        end
    end

    // Write data holding register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            w_full_q <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end else if (w_hs) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata_in;
            wstrb0_q <= s_axi_wstrb_in[0];
        end
    end

    // Write response; unmapped gives slave error
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= fcu_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (reg_decode(wr_addr) >= 3'h4) ? fcu_pkg::RESP_OKAY : fcu_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel; one read in flight, data registered
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= fcu_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= fcu_pkg::RESP_OKAY;
            rdata_q  <= '0;
            case (reg_decode(s_axi_araddr_in))
                {1'b1, fcu_pkg::IDX_CONTROL}: begin
                    // Strobe never reads back as set
                    rdata_q[fcu_pkg::BIT_ENABLE]  <= enable_q;
                    rdata_q[fcu_pkg::BIT_FAIL_IE] <= fail_ie_q;
                end
                {1'b1, fcu_pkg::IDX_SECTION}: begin
                    rdata_q[1:0] <= section_q;
                end
                {1'b1, fcu_pkg::IDX_STATE}: begin
                    // RL15 pass valid only idle
                    rdata_q[fcu_pkg::BIT_BUSY] <= busy;
                    rdata_q[fcu_pkg::BIT_PASS] <= status_q.pass;
                end
                default: begin
                    rresp_q <= fcu_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // Strobe acts one cycle late
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            soft_q <= 1'b0;
        end else begin
            // RL1 act one cycle later
            soft_q <= soft_acc;
        end
    end

    // Enable and failure interrupt enable bits
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            enable_q  <= fcu_pkg::CONTROL_RESET[fcu_pkg::BIT_ENABLE];
            fail_ie_q <= fcu_pkg::CONTROL_RESET[fcu_pkg::BIT_FAIL_IE];
        end else begin
            // RL9 start-up scan sets enable
            if (st_q == fcu_pkg::ST_BOOT && boot_scan_in) begin
                enable_q <= 1'b1;
            end else if (soft_q) begin
                enable_q <= 1'b0;
            end else if (start_req) begin
                enable_q <= 1'b1;
            end
            // RL5 only system reset clears
            if (ie_set) begin
                fail_ie_q <= 1'b1;
            end
        end
    end

    // Section selector
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            section_q <= fcu_pkg::SECTION_RESET;
        end else if (st_q == fcu_pkg::ST_BOOT && boot_scan_in) begin
            // RL13 shows start-up section
            section_q <= boot_section_in;
        end else if (soft_q) begin
            section_q <= fcu_pkg::SECTION_RESET;
        end else if (wr_sect) begin
            section_q <= wr_data[1:0];
        end
    end

    // Scan sequencer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_q   <= fcu_pkg::ST_BOOT;
            cnt_q  <= 2'h0;
            word_q <= '0;
            crc_q  <= fcu_pkg::CRC_INIT;
            boot_q <= 1'b0;
        end else if (soft_q) begin
            // Strobe aborts any scan in progress
            st_q   <= fcu_pkg::ST_IDLE;
            boot_q <= 1'b0;
        end else begin
            case (st_q)
                fcu_pkg::ST_BOOT: begin
                    // Start-up choice sampled once
                    boot_q <= boot_scan_in;
                    cnt_q  <= 2'h1;
                    word_q <= '0;
                    crc_q  <= fcu_pkg::CRC_INIT;
                    st_q   <= boot_scan_in ? fcu_pkg::ST_WAIT : fcu_pkg::ST_IDLE;
                end
                fcu_pkg::ST_IDLE: begin
                    if (start_req) begin
                        cnt_q  <= 2'h1;
                        word_q <= '0;
                        // RL17 accumulator starts all ones
                        crc_q  <= fcu_pkg::CRC_INIT;
                        st_q   <= fcu_pkg::ST_WAIT;
                    end
                end
                fcu_pkg::ST_WAIT: begin
                    // RL18 three cycle start delay
                    if (cnt_q == fcu_pkg::START_DELAY) begin
                        cnt_q <= 2'h1;
                        st_q  <= fcu_pkg::ST_FETCH;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                fcu_pkg::ST_FETCH: begin
                    // RL19 three cycles per word
                    if (cnt_q == fcu_pkg::FETCH_CYCLES) begin
                        cnt_q  <= 2'h1;
                        crc_q  <= crc_d;
                        word_q <= word_q + 1'b1;
                        if (last_word) begin
                            st_q <= fcu_pkg::ST_CHECK;
                        end
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                fcu_pkg::ST_CHECK: begin
                    boot_q <= 1'b0;
                    st_q   <= fcu_pkg::ST_IDLE;
                end
                default: begin
                    st_q <= fcu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pass flag; busy read live from the state
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // RL14 pass flag resets high
            status_q.pass <= fcu_pkg::STATE_RESET[fcu_pkg::BIT_PASS];
            status_q.busy <= fcu_pkg::STATE_RESET[fcu_pkg::BIT_BUSY];
        end else if (soft_q) begin
            status_q.pass <= fcu_pkg::STATE_RESET[fcu_pkg::BIT_PASS];
            status_q.busy <= fcu_pkg::STATE_RESET[fcu_pkg::BIT_BUSY];
        end else begin
            status_q.busy <= busy;
            // RL21 result on completion
            if (st_q == fcu_pkg::ST_CHECK) begin
                status_q.pass <= scan_pass;
            end
        end
    end

    // Sticky request, system reset clears
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nmi_q <= 1'b0;
        end else if (st_q == fcu_pkg::ST_CHECK && !scan_pass && fail_ie_q && !soft_q) begin
            // RL4 mismatch raises request
            nmi_q <= 1'b1;
        end
    end

    // Processor release; a failed start-up scan holds it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            run_q <= 1'b0;
        end else if (st_q == fcu_pkg::ST_BOOT && !boot_scan_in) begin
            run_q <= 1'b1;
        end else if (st_q == fcu_pkg::ST_CHECK && boot_q && !soft_q) begin
            run_q <= scan_pass;
        end
    end

    // Port drive
    assign s_axi_awready_out = !aw_full_q && !bvalid_q;
    assign s_axi_wready_out  = !w_full_q && !bvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    // RL19 scan owns flash port
    assign fl_req_out.rd     = (st_q == fcu_pkg::ST_FETCH);
    assign fl_req_out.addr   = {word_q, 1'b0};
    assign cpu_stall_out     = (st_q == fcu_pkg::ST_FETCH);
    assign cpu_run_out       = run_q;
    assign nmi_out           = nmi_q;
endmodule

// file: sim/fcu_flash_model.sv
// Flash read port model.
`timescale 1ns/1ps
module fcu_flash_model (
    input  wire logic                 clk_in,
    input  wire fcu_pkg::fcu_fl_req_t req_in,
    output logic [15:0]               rdata_out
);
    logic [7:0]  mem [0:15];   // Byte image
    logic [1:0]  cnt_q = 2'h0; // Fetch cycle
    logic [15:0] word;         // Addressed word
    always_ff @(posedge clk_in) begin
        if (!req_in.rd || cnt_q == 2'h2) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    assign word = {mem[{req_in.addr[3:1], 1'b1}], mem[{req_in.addr[3:1], 1'b0}]};
    // Inverted outside the third cycle
    assign rdata_out = (req_in.rd && cnt_q == 2'h2) ? word : ~word;
endmodule

// file: sim/fcu_check_sva.sv
// Port checks of the flash check unit.
`timescale 1ns/1ps
module fcu_check_sva (
    input wire logic                       clk_in,
    input wire logic                       srst_in,
    input wire logic [fcu_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic                       s_axi_awvalid_in,
    input wire logic                       s_axi_awready_out,
    input wire logic [31:0]                s_axi_wdata_in,
    input wire logic                       s_axi_wvalid_in,
    input wire logic                       s_axi_wready_out,
    input wire logic [1:0]                 s_axi_bresp_out,
    input wire logic                       s_axi_bvalid_out,
    input wire fcu_pkg::fcu_fl_req_t       fl_req_out,
    input wire logic                       cpu_stall_out,
    input wire logic                       nmi_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic start; // Enable write taken
    assign start = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out && s_axi_awaddr_in == 4'h0 && s_axi_wdata_in[0]
        && !s_axi_wdata_in[7] && !fl_req_out.rd && !nmi_out;
    a_stall_on_fetch: assert property (cpu_stall_out == fl_req_out.rd)
        else $error("stall differs from fetch");
    a_fetch_three_cycles: assert property ($rose(fl_req_out.rd) |-> fl_req_out.rd [*3])
        else $error("fetch too short");
    a_fetch_from_zero: assert property ($rose(fl_req_out.rd) |-> fl_req_out.addr == 16'h0)
        else $error("scan not from byte zero");
    a_word_aligned: assert property (fl_req_out.rd |-> !fl_req_out.addr[0])
        else $error("odd fetch address");
    a_start_delay: assert property (start |=> !fl_req_out.rd [*3])
        else $error("fetch too early");
    a_nmi_sticky: assert property (nmi_out |=> nmi_out)
        else $error("request dropped");
    a_nmi_after_scan: assert property ($rose(nmi_out) |-> $past(fl_req_out.rd, 2))
        else $error("interrupt off scan end");
    a_no_aw_in_resp: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
        else $error("address taken in response");
    c_fetch: cover property ($rose(fl_req_out.rd));
    c_nmi: cover property ($rose(nmi_out));
    c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule
bind fcu_flash_check_unit fcu_check_sva fcu_check_sva_i (.clk_in, .srst_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .fl_req_out, .cpu_stall_out, .nmi_out);

// file: sim/fcu_flash_check_unit_tb.sv
// Bench of the flash check unit.
`timescale 1ns/1ps
module fcu_flash_check_unit_tb;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [1:0] r;} fcu_row_t;
    logic        clk_in, srst_in, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, bscan, run, nmi;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, bsec;
    logic [15:0] frd, c;
    fcu_pkg::fcu_fl_req_t req;
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    // Rows: write, address, data, response
    fcu_row_t rows [10] = '{'{1'b0, 4'h8, 8'h02, 2'h0}, '{1'b1, 4'h4, 8'h01, 2'h0},
        '{1'b0, 4'h4, 8'h01, 2'h0}, '{1'b1, 4'h4, 8'h00, 2'h0}, '{1'b0, 4'h4, 8'h00, 2'h0},
        '{1'b0, 4'hc, 8'h00, 2'h2}, '{1'b1, 4'hc, 8'h55, 2'h2}, '{1'b0, 4'h0, 8'h01, 2'h0},
        '{1'b1, 4'h0, 8'h00, 2'h0}, '{1'b0, 4'h0, 8'h01, 2'h0}};
    fcu_flash_check_unit fcu_flash_check_unit_i (.clk_in, .srst_in, .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rr), .boot_scan_in(bscan), .boot_section_in(bsec),
        .boot_end_in(16'h0007), .code_end_in(16'h000b), .flash_end_in(16'h000f),
        .fl_req_out(req), .fl_rdata_in(frd), .cpu_stall_out(), .cpu_run_out(run), .nmi_out(nmi));
    fcu_flash_model fcu_flash_model_i (.clk_in, .req_in(req), .rdata_out(frd));
    // Checksum step
    function automatic logic [15:0] crc_b(input logic [15:0] s, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            s = (s[15] ^ b[i]) ? {s[14:0], 1'b0} ^ fcu_pkg::CRC_POLY : {s[14:0], 1'b0};
        end
        return s;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bound used up: fail
    task automatic give_up(input logic hit);
        if (hit) begin
            err_count++;
            end_sim();
        end
    endtask
    // Write; address and data offered together
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
        int k = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv && k < 60);
        br <= 1'b0;
        give_up(k >= 60);
        chk({30'h0, bresp}, {30'h0, e});
        @(posedge clk_in);
    endtask
    // Read into v
    task automatic rdq(input logic [3:0] a);
        int k = 0;
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
            if (arr) arv <= 1'b0;
        end while (!rv && k < 60);
        v = rdata;
        c[1:0] = rresp;
        rr <= 1'b0;
        give_up(k >= 60);
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
        rdq(a);
        chk({30'h0, c[1:0]}, {30'h0, e});
        chk(v, {24'h0, d});
    endtask
    task automatic wait_idle();
        int k = 0;
        do begin
            rdq(4'h8);
            k++;
        end while (v[0] !== 1'b0 && k < 60);
        give_up(k >= 60);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        {srst_in, bscan} = 2'b11;
        {awv, wv, br, arv, rr, awaddr, araddr, wdata} = '0;
        bsec = fcu_pkg::SEC_BOOT;
        c = fcu_pkg::CRC_INIT;
        for (int k = 0; k < 16; k++) begin
            fcu_flash_model_i.mem[k] = 8'(k * 37 + 5);
            if (k < 6) c = crc_b(c, fcu_flash_model_i.mem[k]);
        end
        fcu_flash_model_i.mem[6] = c[15:8];
        fcu_flash_model_i.mem[7] = c[7:0];
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        for (n = 0; run !== 1'b1 && n < 200; n++) @(posedge clk_in);
        give_up(n >= 200);
        bscan <= 1'b0;
        rd(4'h0, 8'h01);
        rd(4'h4, 8'h02);
        rd(4'h8, 8'h02);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
            else rd(rows[i].a, rows[i].d, rows[i].r);
        end
        // Whole flash fails; busy locks writes, pass keeps last result
        wr(4'h0, 8'h01);
        rd(4'h8, 8'h03);
        wr(4'h4, 8'h02);
        wr(4'h0, 8'h02);
        wait_idle();
        rd(4'h8, 8'h00);
        rd(4'h0, 8'h01);
        rd(4'h4, 8'h00);
        chk({31'h0, nmi}, 32'h0);
        // Soft reset mid-scan, interrupt enable clear
        wr(4'h4, 8'h02);
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h8, 8'h02);
        // Interrupt enable survives strobe
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'h02);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h02);
        // Strobe refused mid-scan; failure locks
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h80);
        rd(4'h8, 8'h03);
        wait_idle();
        chk({31'h0, nmi}, 32'h1);
        wr(4'h4, 8'h02);
        wr(4'h0, 8'h80);
        rd(4'h4, 8'h00);
        rd(4'h0, 8'h03);
        end_sim();
    end
endmodule
